/* File: ssw_pkg.sv */
package ssw_pkg;

  // Clock rate in Hz.
  localparam longint CLK_HZ = 64'd25_000_000;

  // Power-on reset delay in milliseconds.
  localparam longint POR_DELAY_MS = 64'd200;
  // Least reset pulse for manual reset and brownout in milliseconds.
  localparam longint MIN_PULSE_MS = 64'd140;
  // Watchdog timeout in milliseconds.
  localparam longint WDOG_TIMEOUT_MS = 64'd1600;
  // Shortest kick pulse that must be seen, in nanoseconds.
  localparam longint KICK_PULSE_NS = 64'd50;

  // Least times round up, the longest time rounds down.
  localparam longint POR_CYCLES = (POR_DELAY_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint MIN_PULSE_CYCLES = (MIN_PULSE_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint WDOG_CYCLES = (WDOG_TIMEOUT_MS * CLK_HZ) / 64'd1000;
  localparam longint KICK_PULSE_CYCLES = (KICK_PULSE_NS * CLK_HZ + 64'd999_999_999)
    / 64'd1_000_000_000;

  // Width of every interval counter.
  localparam int CNT_W = 32;

  // Output build variants.
  typedef enum logic [1:0]
  {
    SSW_VAR_LOW_WDOG = 2'h0,
    SSW_VAR_HIGH_WDOG = 2'h1,
    SSW_VAR_BOTH_NOWDOG = 2'h2
  } ssw_variant_t;

  // Reset generator states, Gray coded along the path.
  typedef enum logic [1:0]
  {
    SSW_RST_HOLD = 2'b00,
    SSW_RST_DELAY = 2'b01,
    SSW_RST_RUN = 2'b11
  } ssw_rst_state_t;

endpackage : ssw_pkg

/* File: ssw_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for one level.
module ssw_sync
  import ssw_pkg::*;
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  // First stage feeds only the second stage.
  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end

  // Register both stages.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1 <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule : ssw_sync

/* File: ssw_timer.sv */
`timescale 1ns/10ps
// Up counter that clears, holds and flags when it reaches its limit.
module ssw_timer
  import ssw_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 32'h0000_0010
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic run,
  output logic done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // Count up while running and stop at the limit.
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (run && count < LIMIT)
      next_count = count + 32'h0000_0001;
  end

  // Register the count.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      count <= '0;
    else
      count <= next_count;
  end

  assign done = (count >= LIMIT);

endmodule : ssw_timer

/* File: ssw_top.sv */
`timescale 1ns/10ps
// Overview of operation
// - Kick silent for timeout drives expiry low.
// - Reset or floating kick keeps counter cleared.
// - Counter runs after reset with driven kick.
// - Short kick pulses clear the counter.
// - Reset released 200ms after supply good, 140ms if supply fell during a delay or manual reset.
// - Supply not good asserts reset.
// - Brownout during pulse extends it 140ms.
// - Reset held low throughout power-down.
// - High reset is complement of low reset in the no-watchdog build only.
// - Supply not good forces expiry low.
// - Floating kick makes expiry a low-line flag.
// - Manual reset starts pulse of 140ms.
// - Power-fail sense low drives warning low.
// - Option: active-high reset output only.
// - Option: no watchdog, both reset polarities.
// - Expiry stays low until next kick, manual reset or floating kick.
// - Expiry released at once on supply good.
module ssw_top
  import ssw_pkg::*;
#(
  parameter ssw_variant_t VARIANT = SSW_VAR_LOW_WDOG,
  parameter logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_CYCLES),
  parameter logic [CNT_W-1:0] PULSE_CNT = CNT_W'(MIN_PULSE_CYCLES),
  parameter logic [CNT_W-1:0] WDOG_CNT = CNT_W'(WDOG_CYCLES)
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic supply_good,
  input wire logic manual_reset_n,
  input wire logic power_fail_sense_in,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  output logic cpu_reset_n,
  output logic cpu_reset,
  output logic watchdog_expired_n,
  output logic power_fail_warn_n
);

  localparam logic HAS_WDOG = (VARIANT != SSW_VAR_BOTH_NOWDOG);

  logic good_s;
  logic mr_n_s;
  logic pfi_s;
  logic kick_s;
  logic float_s;

  // Bring the comparator results and pins into the clock domain.
  ssw_sync #(.INIT(1'b0)) u_sync_good (.core_clk(core_clk), .sys_rst(sys_rst),
    .din(supply_good), .dout(good_s));
  ssw_sync #(.INIT(1'b1)) u_sync_mr (.core_clk(core_clk), .sys_rst(sys_rst),
    .din(manual_reset_n), .dout(mr_n_s));
  ssw_sync #(.INIT(1'b1)) u_sync_pfi (.core_clk(core_clk), .sys_rst(sys_rst),
    .din(power_fail_sense_in), .dout(pfi_s));
  ssw_sync #(.INIT(1'b0)) u_sync_kick (.core_clk(core_clk), .sys_rst(sys_rst),
    .din(watchdog_kick_in), .dout(kick_s));
  ssw_sync #(.INIT(1'b1)) u_sync_float (.core_clk(core_clk), .sys_rst(sys_rst),
    .din(watchdog_kick_float), .dout(float_s));

  ssw_rst_state_t state;
  ssw_rst_state_t next_state;
  logic hold_rst;
  logic next_hold_rst;
  logic tmr_clear;
  logic tmr_run;
  logic tmr_done;
  logic pulse_mode;
  logic next_pulse_mode;
  logic por_done;
  logic pulse_done;

  // One counter measures the power-on delay, a second the least pulse.
  ssw_timer #(.LIMIT(POR_CNT)) u_por_tmr (.core_clk(core_clk), .sys_rst(sys_rst),
    .clear(tmr_clear), .run(tmr_run && !pulse_mode), .done(por_done));
  ssw_timer #(.LIMIT(PULSE_CNT)) u_pulse_tmr (.core_clk(core_clk), .sys_rst(sys_rst),
    .clear(tmr_clear), .run(tmr_run && pulse_mode), .done(pulse_done));

  assign tmr_done = pulse_mode ? pulse_done : por_done;

  // Reset sequencer: hold while supply bad or button held, then time out.
  always_comb
  begin
    next_state = state;
    next_pulse_mode = pulse_mode;
    tmr_clear = 1'b0;
    tmr_run = 1'b0;
    case (state)
      SSW_RST_HOLD:
      begin
        tmr_clear = 1'b1;
        if (good_s && mr_n_s)
          next_state = SSW_RST_DELAY;
      end
      SSW_RST_DELAY:
      begin
        tmr_run = 1'b1;
        if (!good_s)
        begin
          next_state = SSW_RST_HOLD;
          next_pulse_mode = 1'b1;
        end
        else if (!mr_n_s)
        begin
          next_state = SSW_RST_HOLD;
          next_pulse_mode = 1'b1;
        end
        else if (tmr_done)
          next_state = SSW_RST_RUN;
      end
      SSW_RST_RUN:
      begin
        tmr_clear = 1'b1;
        if (!good_s)
        begin
          next_state = SSW_RST_HOLD;
          next_pulse_mode = 1'b0;
        end
        else if (!mr_n_s)
        begin
          next_state = SSW_RST_HOLD;
          next_pulse_mode = 1'b1;
        end
      end
      default:
      begin
        next_state = SSW_RST_HOLD;
        next_pulse_mode = 1'b0;
      end
    endcase
    next_hold_rst = (next_state != SSW_RST_RUN);
  end

  // Register the sequencer.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= SSW_RST_HOLD;
      pulse_mode <= 1'b0;
      hold_rst <= 1'b1;
    end
    else
    begin
      state <= next_state;
      pulse_mode <= next_pulse_mode;
      hold_rst <= next_hold_rst;
    end
  end

  logic kick_prev;
  logic next_kick_prev;
  logic kicked;
  logic [CNT_W-1:0] wd_count;
  logic [CNT_W-1:0] next_wd_count;
  logic expired;
  logic next_expired;
  logic wd_enable;

  assign wd_enable = HAS_WDOG && !hold_rst && !float_s;
  // Every synchronised edge is a kick; a 50 ns pulse spans a clock edge.
  assign kicked = (kick_s != kick_prev);

  // Watchdog counter and sticky expiry flag.
  always_comb
  begin
    next_kick_prev = kick_s;
    next_wd_count = wd_count;
    next_expired = expired;
    if (!wd_enable || kicked)
    begin
      next_wd_count = '0;
      next_expired = 1'b0;
    end
    else if (wd_count < WDOG_CNT)
      next_wd_count = wd_count + 32'h0000_0001;
    else
      next_expired = 1'b1;
  end

  // Register the watchdog.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kick_prev <= 1'b0;
      wd_count <= '0;
      expired <= 1'b0;
    end
    else
    begin
      kick_prev <= next_kick_prev;
      wd_count <= next_wd_count;
      expired <= next_expired;
    end
  end

  logic next_cpu_reset_n;
  logic next_cpu_reset;
  logic next_wdo_n;
  logic next_pfo_n;

  // Output drive per build variant; all outputs leave flip-flops.
  always_comb
  begin
    next_cpu_reset_n = !next_hold_rst;
    next_cpu_reset = next_hold_rst;
    if (VARIANT == SSW_VAR_HIGH_WDOG)
      next_cpu_reset_n = 1'b1;
    next_wdo_n = !(expired || !good_s);
    if (VARIANT == SSW_VAR_BOTH_NOWDOG)
      next_wdo_n = 1'b1;
    else if (VARIANT == SSW_VAR_LOW_WDOG)
      next_cpu_reset = 1'b0;
    next_pfo_n = pfi_s;
  end

  // Register the outputs.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Each build shows its own asserted levels, so the no-watchdog build's reset pair stays complementary.
      cpu_reset_n <= (VARIANT == SSW_VAR_HIGH_WDOG);
      cpu_reset <= (VARIANT != SSW_VAR_LOW_WDOG);
      watchdog_expired_n <= (VARIANT == SSW_VAR_BOTH_NOWDOG);
      power_fail_warn_n <= 1'b0;
    end
    else
    begin
      cpu_reset_n <= next_cpu_reset_n;
      cpu_reset <= next_cpu_reset;
      watchdog_expired_n <= next_wdo_n;
      power_fail_warn_n <= next_pfo_n;
    end
  end

  property p_wdog_expire;
    @(posedge core_clk) disable iff (sys_rst)
    (wd_enable && !kicked && wd_count == WDOG_CNT && good_s) |=> ##1 !watchdog_expired_n;
  endproperty
  a_wdog_expire: assert property (p_wdog_expire) else $error("expiry missed");

  property p_wdog_clear;
    @(posedge core_clk) disable iff (sys_rst)
    (hold_rst || float_s) |=> (wd_count == '0);
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("counter not cleared");

  property p_wdog_count;
    @(posedge core_clk) disable iff (sys_rst)
    (wd_enable && !kicked && wd_count < WDOG_CNT) |=> (wd_count == $past(wd_count) + 1);
  endproperty
  a_wdog_count: assert property (p_wdog_count) else $error("counter stalled");

  property p_kick;
    @(posedge core_clk) disable iff (sys_rst)
    kicked |=> (wd_count == '0 && !expired);
  endproperty
  a_kick: assert property (p_kick) else $error("kick ignored");

  property p_bad_supply;
    @(posedge core_clk) disable iff (sys_rst)
    !good_s |=> (hold_rst && (!watchdog_expired_n || !HAS_WDOG));
  endproperty
  a_bad_supply: assert property (p_bad_supply) else $error("supply fault not seen");

  property p_por_hold;
    @(posedge core_clk) disable iff (sys_rst)
    ($rose(state == SSW_RST_DELAY) && !pulse_mode) |-> hold_rst [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset released early");

  property p_complement;
    @(posedge core_clk) disable iff (sys_rst)
    (VARIANT == SSW_VAR_BOTH_NOWDOG) |-> (cpu_reset == !cpu_reset_n);
  endproperty
  a_complement: assert property (p_complement) else $error("reset pair mismatch");

  property p_pfo;
    @(posedge core_clk) disable iff (sys_rst)
    !pfi_s |=> !power_fail_warn_n;
  endproperty
  a_pfo: assert property (p_pfo) else $error("warning not driven");

  property p_manual;
    @(posedge core_clk) disable iff (sys_rst)
    (!mr_n_s && good_s && state == SSW_RST_RUN) |=> (hold_rst && pulse_mode);
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset ignored");

  property p_release;
    @(posedge core_clk) disable iff (sys_rst)
    (good_s && !expired && HAS_WDOG) |=> watchdog_expired_n;
  endproperty
  a_release: assert property (p_release) else $error("expiry not released");

  // The high-only build keeps the low output idle and follows the sequencer.
  property p_high_only;
    @(posedge core_clk) disable iff (sys_rst)
    (VARIANT == SSW_VAR_HIGH_WDOG) |-> (cpu_reset_n && cpu_reset == hold_rst);
  endproperty
  a_high_only: assert property (p_high_only) else $error("high-only reset wrong");

  // The build without a watchdog never flags expiry.
  property p_nowdog;
    @(posedge core_clk) disable iff (sys_rst)
    (VARIANT == SSW_VAR_BOTH_NOWDOG) |-> (watchdog_expired_n && cpu_reset_n != hold_rst);
  endproperty
  a_nowdog: assert property (p_nowdog) else $error("no-watchdog build wrong");

endmodule : ssw_top

/* File: ssw_cpu_model.sv */
`timescale 1ns/10ps
// Processor model that kicks the watchdog with one-cycle pulses while it runs.
module ssw_cpu_model
  import ssw_pkg::*;
(
  input wire logic core_clk,
  input wire logic cpu_reset_n,
  input wire logic kick_en,
  input wire logic [7:0] kick_gap,
  output logic watchdog_kick_in
);
  logic [7:0] gap_cnt;

  // The line starts low and quiet.
  initial
  begin
    gap_cnt = 8'h00;
    watchdog_kick_in = 1'b0;
  end

  // A held processor cannot kick, so the gap restarts while in reset.
  always @(posedge core_clk)
  begin
    watchdog_kick_in <= 1'b0;
    if (!cpu_reset_n || !kick_en)
      gap_cnt <= 8'h00;
    else if (gap_cnt >= kick_gap)
    begin
      gap_cnt <= 8'h00;
      watchdog_kick_in <= 1'b1;
    end
    else
      gap_cnt <= gap_cnt + 8'h01;
  end
endmodule : ssw_cpu_model

/* File: tb_ssw_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the supervisor beside a kicking processor model.
module tb_ssw_top;
  import ssw_pkg::*;
  localparam int POR_N = 20;
  localparam int PULSE_N = 14;
  localparam int WDOG_N = 50;
  logic core_clk, sys_rst, supply_good, manual_reset_n, power_fail_sense_in;
  logic watchdog_kick_in, watchdog_kick_float, kick_en;
  logic cpu_reset_n, cpu_reset, watchdog_expired_n, power_fail_warn_n;
  logic [7:0] kick_gap;
  logic h_rst_n, h_rst, b_rst_n, b_rst, b_wdo_n, low;
  int fails = 0;
  int n_checks = 0;

  ssw_top #(.POR_CNT(CNT_W'(POR_N)), .PULSE_CNT(CNT_W'(PULSE_N)),
    .WDOG_CNT(CNT_W'(WDOG_N))) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .supply_good(supply_good), .manual_reset_n(manual_reset_n),
    .power_fail_sense_in(power_fail_sense_in), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_float(watchdog_kick_float), .cpu_reset_n(cpu_reset_n),
    .cpu_reset(cpu_reset), .watchdog_expired_n(watchdog_expired_n),
    .power_fail_warn_n(power_fail_warn_n));

  ssw_cpu_model cpu_u (.core_clk(core_clk), .cpu_reset_n(cpu_reset_n),
    .kick_en(kick_en), .kick_gap(kick_gap), .watchdog_kick_in(watchdog_kick_in));

  // The two other builds share every input with the main one.
  ssw_top #(.VARIANT(SSW_VAR_HIGH_WDOG), .POR_CNT(CNT_W'(POR_N)),
    .PULSE_CNT(CNT_W'(PULSE_N)), .WDOG_CNT(CNT_W'(WDOG_N))) dut_h (.core_clk(core_clk),
    .sys_rst(sys_rst), .supply_good(supply_good), .manual_reset_n(manual_reset_n),
    .power_fail_sense_in(power_fail_sense_in), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_float(watchdog_kick_float), .cpu_reset_n(h_rst_n), .cpu_reset(h_rst),
    .watchdog_expired_n(), .power_fail_warn_n());

  ssw_top #(.VARIANT(SSW_VAR_BOTH_NOWDOG), .POR_CNT(CNT_W'(POR_N)),
    .PULSE_CNT(CNT_W'(PULSE_N)), .WDOG_CNT(CNT_W'(WDOG_N))) dut_b (.core_clk(core_clk),
    .sys_rst(sys_rst), .supply_good(supply_good), .manual_reset_n(manual_reset_n),
    .power_fail_sense_in(power_fail_sense_in), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_float(watchdog_kick_float), .cpu_reset_n(b_rst_n), .cpu_reset(b_rst),
    .watchdog_expired_n(b_wdo_n), .power_fail_warn_n());

  // The warning output follows the sense input.
  function automatic logic exp_warn(input logic s);
    return s;
  endfunction : exp_warn

  // Reset is held while supply is bad or the button is pressed.
  function automatic logic exp_rst_n(input logic g, input logic m);
    return g & m;
  endfunction : exp_rst_n

  task automatic chk(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Waits at most n cycles for the chosen output to reach v, then checks it.
  task automatic wchk(input bit sel, input logic v, input int n);
    int k;
    k = 0;
    while ((sel ? watchdog_expired_n : cpu_reset_n) !== v && k < n)
    begin
      @(negedge core_clk);
      k++;
    end
    chk(sel ? "watchdog_expired_n" : "cpu_reset_n", v,
      sel ? watchdog_expired_n : cpu_reset_n);
  endtask : wchk

  // Checks the idle reset pins, b_wdo_n and the other two builds' active reset pins against the expected active-low level e.
  task automatic chk_var(input logic e);
    chk("cpu_reset", 1'b0, cpu_reset);
    chk("h_rst_n", 1'b1, h_rst_n);
    chk("h_rst", !e, h_rst);
    chk("b_rst_n", e, b_rst_n);
    chk("b_rst", !e, b_rst);
    chk("b_wdo_n", 1'b1, b_wdo_n);
  endtask : chk_var

  // Feeds an output back into the manual reset input for n cycles, as a board would.
  task automatic tie(input bit sel, input int n, output logic saw_low);
    logic v;
    v = 1'b1;
    saw_low = 1'b0;
    repeat (n)
    begin
      @(posedge core_clk);
      manual_reset_n <= v;
      @(negedge core_clk);
      v = sel ? watchdog_expired_n : power_fail_warn_n;
      if (cpu_reset_n === 1'b0)
        saw_low = 1'b1;
    end
  endtask : tie

  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Free-running 25 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (6000) @(posedge core_clk);
    fails++;
    test_done();
  end

  // Main sequence of scenarios.
  initial
  begin
    sys_rst = 1'b1;
    supply_good = 1'b0;
    manual_reset_n = 1'b1;
    power_fail_sense_in = 1'b1;
    watchdog_kick_float = 1'b0;
    kick_en = 1'b1;
    kick_gap = 8'h04;
    void'($urandom(28099));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(4);
    chk("cpu_reset_n", exp_rst_n(supply_good, manual_reset_n), cpu_reset_n);
    chk("watchdog_expired_n", 1'b0, watchdog_expired_n);
    chk_var(1'b0);
    @(posedge core_clk);
    supply_good <= 1'b1;
    cyc(4);
    chk("watchdog_expired_n", 1'b1, watchdog_expired_n);
    cyc(POR_N - 4);
    chk("cpu_reset_n", 1'b0, cpu_reset_n);
    wchk(0, 1'b1, 10);
    chk_var(1'b1);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      power_fail_sense_in <= (i < 2) ? i[0] : 1'($urandom);
      cyc(4);
      chk("power_fail_warn_n", exp_warn(power_fail_sense_in), power_fail_warn_n);
    end
    @(posedge core_clk);
    kick_gap <= 8'(5 + $urandom % 30);
    cyc(3 * WDOG_N);
    chk("watchdog_expired_n", 1'b1, watchdog_expired_n);
    @(posedge core_clk);
    kick_gap <= 8'h04;
    cyc(10);
    @(posedge core_clk);
    kick_en <= 1'b0;
    cyc(WDOG_N - 6);
    chk("watchdog_expired_n", 1'b1, watchdog_expired_n);
    wchk(1, 1'b0, 20);
    cyc(30);
    chk("watchdog_expired_n", 1'b0, watchdog_expired_n);
    @(posedge core_clk);
    kick_en <= 1'b1;
    wchk(1, 1'b1, 12);
    @(posedge core_clk);
    kick_en <= 1'b0;
    watchdog_kick_float <= 1'b1;
    cyc(3 * WDOG_N);
    chk("watchdog_expired_n", 1'b1, watchdog_expired_n);
    @(posedge core_clk);
    supply_good <= 1'b0;
    cyc(4);
    chk("watchdog_expired_n", 1'b0, watchdog_expired_n);
    chk("cpu_reset_n", 1'b0, cpu_reset_n);
    chk_var(1'b0);
    cyc(30);
    chk("cpu_reset_n", 1'b0, cpu_reset_n);
    @(posedge core_clk);
    supply_good <= 1'b1;
    cyc(4);
    chk("watchdog_expired_n", 1'b1, watchdog_expired_n);
    cyc(POR_N - 4);
    chk("cpu_reset_n", 1'b0, cpu_reset_n);
    wchk(0, 1'b1, 10);
    @(posedge core_clk);
    watchdog_kick_float <= 1'b0;
    kick_en <= 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge core_clk);
      manual_reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      manual_reset_n <= 1'b1;
      cyc(2);
      chk("cpu_reset_n", 1'b0, cpu_reset_n);
      chk_var(1'b0);
      if (b == 1)
      begin
        cyc(PULSE_N / 2);
        @(posedge core_clk);
        supply_good <= 1'b0;
        repeat (3) @(posedge core_clk);
        supply_good <= 1'b1;
      end
      cyc(PULSE_N);
      chk("cpu_reset_n", 1'b0, cpu_reset_n);
      wchk(0, 1'b1, 10);
    end
    // Warning output wired back to the manual reset input.
    @(posedge core_clk);
    power_fail_sense_in <= 1'b0;
    tie(0, 12, low);
    chk("saw cpu_reset_n low", 1'b1, low);
    @(posedge core_clk);
    power_fail_sense_in <= 1'b1;
    tie(0, PULSE_N + 20, low);
    chk("cpu_reset_n", 1'b1, cpu_reset_n);
    chk_var(1'b1);
    // Expiry output wired back to the manual reset input.
    @(posedge core_clk);
    kick_en <= 1'b0;
    tie(1, WDOG_N + 30, low);
    chk("saw cpu_reset_n low", 1'b1, low);
    @(posedge core_clk);
    manual_reset_n <= 1'b1;
    kick_en <= 1'b1;
    wchk(0, 1'b1, PULSE_N + 20);
    test_done();
  end
endmodule : tb_ssw_top
